// ---- design/sadc_pkg.sv ----
// Purpose: shared constants and types for the sar converter sequencer
// Assumes: one machine cycle per sys_clk edge
// Notes: channel codes 0..3 external pins, 4..7 reference chain taps
package sadc_pkg;
    localparam int SADC_CONV_CYCLES = 30;
    localparam int SADC_SAMPLE_CYCLES = 5;
    localparam int SADC_CNT_W = 5;
    localparam logic [7:0] SADC_RESULT_RST = 8'h00;
    localparam logic [7:0] SADC_TRIAL_MSB = 8'h80;
    localparam logic [7:0] SADC_CODE_MAX = 8'hFF;
    localparam logic [2:0] SADC_CHAN_RST = 3'h0;
    localparam int SADC_DONE_BIT = 7;
    localparam int SADC_CHAN_LSB = 0;
    localparam int SADC_EXT_CHANNELS = 4;
    // machine cycles between two search decisions: dac flop plus two sync flops
    localparam int SADC_STEP_CYCLES = 3;
    localparam int SADC_CODE_BITS = 8;

    typedef enum logic [2:0] {
        SADC_ST_SAMPLE = 3'b001,
        SADC_ST_HOLD = 3'b010,
        SADC_ST_IDLE = 3'b100
    } sadc_state_t;

    // analog front-end controls driven by the sequencer
    typedef struct packed {
        logic sample_en;
        logic ext_sel;
        logic [1:0] ext_chan;
        logic [1:0] tap_sel;
        logic [7:0] dac_code;
    } sadc_afe_t;
endpackage

// ---- design/sadc_sar_step.sv ----
// Purpose: one successive approximation step on the approximation register
// Assumes: comparator high means sampled input above the dac level
// Notes: purely combinational, used once per decision, every third hold cycle
`timescale 1ns/10ps
module sadc_sar_step
    import sadc_pkg::*;
(
    input wire logic [7:0] approx_cur, // current approximation value
    input wire logic [7:0] trial_bit, // one-hot bit under test
    input wire logic comp_above, // input above dac
    output logic [7:0] approx_nxt, // value after decision
    output logic [7:0] trial_nxt // next lower trial bit
);
    always_comb
    begin
        approx_nxt = comp_above ? approx_cur : (approx_cur & ~trial_bit);
        trial_nxt = trial_bit >> 1;
        approx_nxt = approx_nxt | trial_nxt;
    end
endmodule // sadc_sar_step

// ---- design/sadc_seq.sv ----
// Purpose: control and sequencing of an 8-bit successive approximation converter
// Assumes: sys_clk is the machine cycle; comparator is asynchronous to it
// Notes: registers are reached through plain write/read ports, no bus
`timescale 1ns/10ps
module sadc_seq
    import sadc_pkg::*;
(
    input wire logic sys_clk, // machine cycle clock
    input wire logic resetn, // async reset, active low
    input wire logic ctrl_wr, // write strobe to control register
    input wire logic [7:0] ctrl_wdata, // control write data
    input wire logic ctrl_rd, // read strobe of control register, clears done
    input wire logic comp_above_pin, // raw comparator output
    output logic [7:0] converter_control_register, // control readback
    output logic [7:0] conversion_result_register, // result readback
    output sadc_afe_t afe_q // analog front-end controls
);
    localparam int PACE_W = $clog2(SADC_STEP_CYCLES);

    sadc_state_t state_q;
    logic [SADC_CNT_W-1:0] cyc_q;
    logic [2:0] chan_q;
    logic done_q;
    logic [7:0] approximation_register;
    logic [7:0] trial_q;
    logic [7:0] result_q;
    logic comp_s1_q;
    logic comp_s2_q;
    logic [7:0] approx_nxt;
    logic [7:0] trial_nxt;
    logic last_cyc;
    logic sample_end;
    logic [PACE_W-1:0] pace_q;
    logic load_trial;
    logic step_now;
    logic [7:0] approx_d;
    logic [7:0] trial_d;
    logic sample_next;

    // the whole search has to fit behind the sample window inside one frame
    if (SADC_SAMPLE_CYCLES + SADC_CODE_BITS * SADC_STEP_CYCLES > SADC_CONV_CYCLES - 1)
    begin : g_bad_timing
        $error("frame too short for the search");
    end

    // fewer than three cycles per decision would read a stale comparator level
    if (SADC_CONV_CYCLES > (1 << SADC_CNT_W) || SADC_STEP_CYCLES < 3)
    begin : g_bad_counts
        $error("cycle counts out of range");
    end

    // comparator is an analog level, two flops before use
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            comp_s1_q <= 1'b0;
            comp_s2_q <= 1'b0;
        end
        else
        begin
            comp_s1_q <= comp_above_pin;
            comp_s2_q <= comp_s1_q;
        end
    end

    assign last_cyc = (cyc_q == SADC_CNT_W'(SADC_CONV_CYCLES - 1));
    assign sample_end = (cyc_q == SADC_CNT_W'(SADC_SAMPLE_CYCLES - 1));

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            cyc_q <= '0;
        // held at zero while idle so the first frame after reset is complete
        else if (ctrl_wr || last_cyc || state_q == SADC_ST_IDLE)
            cyc_q <= '0;
        else
            cyc_q <= cyc_q + SADC_CNT_W'(1);
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            state_q <= SADC_ST_IDLE;
        else
        begin
            case (state_q)
                SADC_ST_IDLE:
                    state_q <= SADC_ST_SAMPLE;
                SADC_ST_SAMPLE:
                    if (ctrl_wr)
                        state_q <= SADC_ST_SAMPLE;
                    else if (sample_end)
                        state_q <= SADC_ST_HOLD;
                SADC_ST_HOLD:
                    if (ctrl_wr || last_cyc)
                        state_q <= SADC_ST_SAMPLE;
                default:
                    state_q <= SADC_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            chan_q <= SADC_CHAN_RST;
        else if (ctrl_wr)
            chan_q <= ctrl_wdata[SADC_CHAN_LSB +: 3];
    end

    // done flag; a completion in a read cycle wins, a write in that cycle cancels it
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            done_q <= 1'b0;
        else if (state_q == SADC_ST_HOLD && last_cyc && !ctrl_wr)
            done_q <= 1'b1;
        else if (ctrl_wr || ctrl_rd)
            done_q <= 1'b0;
    end

    sadc_sar_step u_step (
        .approx_cur(approximation_register),
        .trial_bit(trial_q),
        .comp_above(comp_s2_q),
        .approx_nxt(approx_nxt),
        .trial_nxt(trial_nxt)
    );

    // msb trial when the window closes, then one decision per pace
    assign load_trial = (state_q == SADC_ST_SAMPLE) && sample_end && !ctrl_wr;
    assign step_now = (state_q == SADC_ST_HOLD) && (trial_q != 8'h00)
        && (pace_q == PACE_W'(SADC_STEP_CYCLES - 1));

    // a decision waits for the dac flop and both sync flops, so the level
    // it reads belongs to the trial under test and not to an older one
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            pace_q <= '0;
        else if (load_trial || step_now)
            pace_q <= '0;
        else if (state_q == SADC_ST_HOLD)
            pace_q <= pace_q + PACE_W'(1);
    end

    // binary search; high input keeps every bit, giving FF
    always_comb
    begin
        approx_d = approximation_register;
        trial_d = trial_q;
        if (load_trial)
        begin
            approx_d = SADC_TRIAL_MSB;
            trial_d = SADC_TRIAL_MSB;
        end
        else if (step_now)
        begin
            approx_d = approx_nxt;
            trial_d = trial_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            approximation_register <= SADC_RESULT_RST;
            trial_q <= '0;
        end
        else
        begin
            approximation_register <= approx_d;
            trial_q <= trial_d;
        end
    end

    // copy at end; hold until next completion
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            result_q <= SADC_RESULT_RST;
        else if (state_q == SADC_ST_HOLD && last_cyc && !ctrl_wr)
            result_q <= approximation_register;
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            converter_control_register <= 8'h00;
            conversion_result_register <= SADC_RESULT_RST;
        end
        else
        begin
            converter_control_register <= {done_q, 4'h0, chan_q};
            conversion_result_register <= result_q;
        end
    end

    // switch closed exactly while the state is sample, so the
    // registered enable is fed from the state's next value
    always_comb
    begin
        case (state_q)
            SADC_ST_IDLE:
                sample_next = 1'b1;
            SADC_ST_SAMPLE:
                sample_next = ctrl_wr || !sample_end;
            SADC_ST_HOLD:
                sample_next = ctrl_wr || last_cyc;
            default:
                sample_next = 1'b0;
        endcase
    end

    // upper codes route reference taps, not pins
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            afe_q <= '0;
        else
        begin
            afe_q.sample_en <= sample_next;
            afe_q.ext_sel <= (chan_q < 3'(SADC_EXT_CHANNELS));
            afe_q.ext_chan <= chan_q[1:0];
            afe_q.tap_sel <= chan_q[1:0];
            // dac takes the register's next value, one cycle less per decision
            afe_q.dac_code <= approx_d;
        end
    end
endmodule // sadc_seq

// ---- tb/sadc_afe_model.sv ----
// Purpose: channel mux, sample hold and comparator
// Assumes: vin is 9 bits so values above FF lie over reference_high
// Notes: external channel c reads vin xor c, taps read fixed codes
`timescale 1ns/10ps
module sadc_afe_model
    import sadc_pkg::*;
(
    input wire logic sys_clk, // clock
    input wire sadc_afe_t afe_q, // controls
    input wire logic [8:0] vin, // pin level
    output logic comp_above // comparator
);
    logic [8:0] held_q = 9'h000;
    wire logic [8:0] mux = afe_q.ext_sel ? vin ^ {7'h00, afe_q.ext_chan}
        : {1'b0, afe_q.tap_sel, 6'h20};
    always_ff @(posedge sys_clk)
        if (afe_q.sample_en) held_q <= mux;
    assign comp_above = held_q >= {1'b0, afe_q.dac_code};
endmodule // sadc_afe_model

// ---- tb/sadc_seq_checker.sv ----
// Purpose: port checks for sadc_seq
// Assumes: sees the top ports only
// Notes: age_q masks frames cut short by a write
`timescale 1ns/10ps
module sadc_seq_checker
    import sadc_pkg::*;
(
    input wire logic sys_clk, // clock
    input wire logic resetn, // reset
    input wire logic ctrl_wr, // write
    input wire logic [7:0] ctrl_wdata, // data
    input wire logic [7:0] converter_control_register, // control
    input wire logic [7:0] conversion_result_register, // result
    input wire sadc_afe_t afe_q // front end
);
    logic [5:0] age_q;
    wire logic [7:0] cr = converter_control_register;
    wire logic se = afe_q.sample_en;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            age_q <= 6'h00;
        else if (ctrl_wr)
            age_q <= 6'h00;
        else if (age_q != 6'h3F)
            age_q <= age_q + 6'h01;
    end
    a_frame_period: assert property ($rose(se) && age_q > 6'h20 |->
        $past(se, 30) && !$past(se, 31)) else $error("frame not 30 cycles");
    a_sample_len: assert property ($fell(se) && age_q > 6'h08 |->
        $past(se, 5) && !$past(se, 6)) else $error("sample not 5 cycles");
    a_trial_msb: assert property ($fell(se) && age_q > 6'h08 |->
        ##[0:1] afe_q.dac_code == SADC_TRIAL_MSB) else $error("no msb trial");
    a_result_hold: assert property ($changed(conversion_result_register) |-> cr[7])
        else $error("result moved without done");
    a_ctrl_zero: assert property (cr[6:3] == 4'h0) else $error("control bits 6:3 set");
    a_chan_echo: assert property (ctrl_wr |-> ##2 cr[2:0] == $past(ctrl_wdata[2:0], 2))
        else $error("channel readback wrong");
    a_wr_clears: assert property (ctrl_wr |-> ##2 !cr[7]) else $error("done kept");
    a_chan_route: assert property (age_q > 6'h03 |-> afe_q.ext_sel == !cr[2] &&
        (cr[2] ? afe_q.tap_sel : afe_q.ext_chan) == cr[1:0]) else $error("bad route");
    c_done: cover property ($rose(cr[7]));
    c_abort: cover property (ctrl_wr && !se);
    c_tap: cover property (!afe_q.ext_sel && cr[7]);
endmodule // sadc_seq_checker

bind sadc_seq sadc_seq_checker u_chk (.sys_clk, .resetn, .ctrl_wr, .ctrl_wdata,
    .converter_control_register, .conversion_result_register, .afe_q);

// ---- tb/sadc_seq_test.sv ----
// Purpose: self-checking bench for sadc_seq
// Assumes: front end model answers at once
// Notes: each task judges its own outcome
`timescale 1ns/10ps
module sadc_seq_test
    import sadc_pkg::*;
;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic ctrl_wr = 1'b0;
    logic [7:0] ctrl_wdata = 8'h00;
    logic ctrl_rd = 1'b0;
    logic [8:0] vin = 9'h000;
    logic comp_above_pin;
    logic [7:0] ccr;
    logic [7:0] res;
    sadc_afe_t afe_q;
    int errors = 0;
    int checks = 0;
    always #12.5 sys_clk = ~sys_clk;
    sadc_seq dut (.sys_clk, .resetn, .ctrl_wr, .ctrl_wdata, .ctrl_rd, .comp_above_pin,
        .converter_control_register(ccr), .conversion_result_register(res), .afe_q);
    sadc_afe_model u_afe (.sys_clk, .afe_q, .vin, .comp_above(comp_above_pin));
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] ch);
        ctrl_wdata = {5'h00, ch};
        ctrl_wr = 1'b1;
        tick(1);
        ctrl_wr = 1'b0;
        tick(1);
    endtask
    task automatic wait_done(output int n);
        n = 0;
        while (ccr[7] !== 1'b1 && n < 80)
        begin
            tick(1);
            n++;
        end
        if (ccr[7] !== 1'b1)
        begin
            errors++;
            $display("BAD done flag expected 1 seen %b", ccr[7]);
        end
    endtask
    task automatic t_codes;
        int n;
        logic [8:0] v;
        for (int c = 0; c < 8; c++)
        begin
            v = {c[1], 8'(c * 85)};
            vin = v;
            wr(3'(c));
            wait_done(n);
            chk("control", {5'h10, 3'(c)}, ccr);
            chk("result", c > 3 ? {c[1:0], 6'h20} : v[8] ? SADC_CODE_MAX : v[7:0] ^ 8'(c), res);
        end
        $display("t_codes done");
    endtask
    task automatic t_period;
        int n;
        ctrl_rd = 1'b1;
        tick(1);
        ctrl_rd = 1'b0;
        tick(1);
        chk("done after read", 8'h00, {7'h00, ccr[7]});
        wait_done(n);
        chk("period", 8'(SADC_CONV_CYCLES), 8'(n + 2));
        $display("t_period done");
    endtask
    task automatic t_abort;
        int n;
        vin = 9'h0AA;
        wr(3'h1);
        tick(15);
        wr(3'h1);
        tick(26);
        // last completed frame read reference tap 7
        chk("kept result", 8'hE0, res);
        chk("no done", 8'h00, {7'h00, ccr[7]});
        wait_done(n);
        chk("new result", 8'hAB, res);
        $display("t_abort done");
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #50000;
        errors++;
        test_done();
    end
    initial
    begin
        tick(4);
        chk("reset result", SADC_RESULT_RST, res);
        resetn = 1'b1;
        tick(2);
        t_codes();
        t_period();
        t_abort();
        test_done();
    end
endmodule // sadc_seq_test
